/* File: core/acr_top.sv */
`timescale 1ns/1ns
//////////////////////////////////////////////////////////////////////////////////////////
// Behaviour
// - Single-ended result is unsigned; ground is 0x000, reference minus one step 0x3FF.
// - Single-ended code is input times 1024 over reference, truncated.
// - Differential code is difference times gain times 512 over reference, clamped.
// - For differential results, bit nine is one exactly when the result is negative.
// - Result bytes hold the completed result whenever the done flag is high.
// - Reference field selects external pin, analog supply, reserved or internal 2.56V.
// - Reference changes during a conversion take effect only after it completes.
// - Input selection changes during a conversion take effect only after it completes.
// - Alignment bit left- or right-aligns the result, immediately, even mid-conversion.
// - Codes 0-7 pick single inputs; 11110 bandgap; 11111 ground.
// - Codes 01000 to 11101 pick differential pairs with 1x, 10x or 200x gain.
// - Same-pin differential codes are supported for offset calibration.
// - Enable one turns converter on; zero turns it off and aborts conversion.
// - Registers decode at I/O offsets and at offsets plus 0x20 in data space.
// - Reading the low byte freezes result bytes until the high byte is read.
// - Done flag sets at completion, or at the high-byte read if it completes while frozen; cleared by vector execution or writing one.
// - Start bit begins conversion, reads one while converting, free running included; first takes 25 clocks.
// - Prescaler divides system clock by 2, 2, 4 ... 128 for the converter clock.
//////////////////////////////////////////////////////////////////////////////////////////
module acr_top
  import acr_pkg::*;
(
  // Clock and reset
  input  wire logic               CLK,
  input  wire logic               RESETN,
  // Internal I/O register port
  input  wire logic [7:0]         IO_ADDR,
  input  wire logic               IO_DATA_SPACE,
  input  wire logic               IO_RD,
  input  wire logic               IO_WR,
  input  wire logic [7:0]         IO_WDATA,
  output logic      [7:0]         IO_RDATA,
  input  wire logic               IO_VECTOR_ACK,
  output logic                    CONV_IRQ,
  // Conversion core
  input  wire logic signed [15:0] CORE_SAMPLE,
  output logic                    CORE_EN,
  output logic                    CORE_CONVERTING,
  output logic                    CORE_CLK_TICK,
  output logic      [1:0]         CORE_REF_SEL,
  output logic      [4:0]         CORE_INPUT_CODE,
  output logic      [1:0]         CORE_GAIN
);

  typedef enum logic {ST_IDLE, ST_CONV} acr_state_e;

  acr_state_e  state_ff;
  logic [7:0]  sel_ff;
  logic        en_ff, fr_ff, flag_ff, ie_ff;
  logic [2:0]  ps_ff;
  logic [1:0]  act_ref_ff;
  logic [4:0]  act_code_ff;
  logic [6:0]  pre_cnt_ff;
  logic [4:0]  conv_cnt_ff;
  logic [4:0]  len_ff;
  logic        first_ff;
  logic [9:0]  result_ff;
  logic [9:0]  pend_ff;
  logic        pend_v_ff;
  logic        frozen_ff;
  logic        tick;
  logic        done;
  logic        start_req;
  logic        load_now;
  logic        set_flag;
  logic [9:0]  fmt_res;
  logic [9:0]  load_val;
  logic [7:0]  nxt_rdata;
  logic        wr_ctrl, wr_sel, rd_lo, rd_hi, rd_ctrl, rd_sel;

  //////////////////////////////////////////////////////////////////////////////////////////
  // Address decode

  assign wr_ctrl = IO_WR && acr_hit(IO_ADDR, IO_DATA_SPACE, OFS_CTRL);
  assign wr_sel  = IO_WR && acr_hit(IO_ADDR, IO_DATA_SPACE, OFS_SEL);
  assign rd_lo   = IO_RD && acr_hit(IO_ADDR, IO_DATA_SPACE, OFS_RES_LO);
  assign rd_hi   = IO_RD && acr_hit(IO_ADDR, IO_DATA_SPACE, OFS_RES_HI);
  assign rd_ctrl = IO_RD && acr_hit(IO_ADDR, IO_DATA_SPACE, OFS_CTRL);
  assign rd_sel  = IO_RD && acr_hit(IO_ADDR, IO_DATA_SPACE, OFS_SEL);

  //////////////////////////////////////////////////////////////////////////////////////////
  // Control register fields

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      en_ff <= 1'b0;
      fr_ff <= 1'b0;
      ie_ff <= 1'b0;
      ps_ff <= 3'h0;
    end else if (wr_ctrl) begin
      en_ff <= IO_WDATA[CS_EN];
      fr_ff <= IO_WDATA[CS_FREE];
      ie_ff <= IO_WDATA[CS_IE];
      ps_ff <= IO_WDATA[2:0];
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      sel_ff <= RESET_VAL;
    end else if (wr_sel) begin
      sel_ff <= IO_WDATA;
    end
  end

  // The written selection is copied to the core only between conversions.
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      act_ref_ff  <= REF_EXT_PIN;
      act_code_ff <= 5'h00;
    end else if (state_ff == ST_IDLE || done) begin
      act_ref_ff  <= sel_ff[7:6];
      act_code_ff <= sel_ff[4:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////
  // Prescaler and conversion sequencing

  assign tick = (pre_cnt_ff & acr_div_mask(ps_ff)) == acr_div_mask(ps_ff);

  always_ff @(posedge CLK) begin
    if (!RESETN || !en_ff) begin
      pre_cnt_ff <= 7'h00;
    end else begin
      pre_cnt_ff <= pre_cnt_ff + 7'h01;
    end
  end

  // Start is honoured while enabled or together with the enabling write.
  assign start_req = wr_ctrl && IO_WDATA[CS_START] && IO_WDATA[CS_EN];
  assign done      = (state_ff == ST_CONV) && en_ff && tick
                     && (conv_cnt_ff == 5'(len_ff - 5'd1));

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      first_ff <= 1'b1;
    end else if (!en_ff) begin
      first_ff <= 1'b1;
    end else if (done) begin
      first_ff <= 1'b0;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      state_ff    <= ST_IDLE;
      conv_cnt_ff <= 5'h00;
      len_ff      <= NORMAL_CONV_CLKS;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          if (start_req) begin
            state_ff    <= ST_CONV;
            conv_cnt_ff <= 5'h00;
            len_ff      <= (first_ff || !en_ff) ? FIRST_CONV_CLKS : NORMAL_CONV_CLKS;
          end
        end
        ST_CONV: begin
          if (wr_ctrl && !IO_WDATA[CS_EN]) begin
            state_ff <= ST_IDLE;
          end else if (done) begin
            conv_cnt_ff <= 5'h00;
            len_ff      <= NORMAL_CONV_CLKS;
            if (!fr_ff) begin
              state_ff <= ST_IDLE;
            end
          end else if (tick) begin
            conv_cnt_ff <= conv_cnt_ff + 5'd1;
          end
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////
  // Result storage, freeze and done flag

  acr_fmt i_acr_fmt (
    .code   (act_code_ff),
    .sample (CORE_SAMPLE),
    .res    (fmt_res)
  );

  // A result that completes while frozen waits here and is released by the high-byte read,
  // so the flag never rises without its data.
  assign load_now = (done && (!frozen_ff || rd_hi)) || (pend_v_ff && rd_hi);
  assign load_val = (pend_v_ff && rd_hi && !done) ? pend_ff : fmt_res;
  assign set_flag = load_now;

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      frozen_ff <= 1'b0;
    end else if (rd_hi) begin
      frozen_ff <= 1'b0;
    end else if (rd_lo) begin
      frozen_ff <= 1'b1;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      pend_v_ff <= 1'b0;
      pend_ff   <= 10'h000;
    end else if (done && frozen_ff && !rd_hi) begin
      pend_v_ff <= 1'b1;
      pend_ff   <= fmt_res;
    end else if (rd_hi) begin
      pend_v_ff <= 1'b0;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      result_ff <= 10'h000;
    end else if (load_now) begin
      result_ff <= load_val;
    end
  end

  // Setting wins over any clear in the same cycle.
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      flag_ff <= 1'b0;
    end else if (set_flag) begin
      flag_ff <= 1'b1;
    end else if (IO_VECTOR_ACK || (wr_ctrl && IO_WDATA[CS_FLAG])) begin
      flag_ff <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////
  // Read data and core outputs

  always_comb begin
    nxt_rdata = 8'h00;
    if (rd_lo) begin
      nxt_rdata = sel_ff[SEL_ALIGN] ? {result_ff[1:0], 6'h00} : result_ff[7:0];
    end else if (rd_hi) begin
      nxt_rdata = sel_ff[SEL_ALIGN] ? result_ff[9:2] : {6'h00, result_ff[9:8]};
    end else if (rd_ctrl) begin
      nxt_rdata = {en_ff, state_ff == ST_CONV, fr_ff, flag_ff, ie_ff, ps_ff};
    end else if (rd_sel) begin
      nxt_rdata = sel_ff;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      IO_RDATA <= 8'h00;
    end else begin
      IO_RDATA <= nxt_rdata;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      CONV_IRQ        <= 1'b0;
      CORE_EN         <= 1'b0;
      CORE_CONVERTING <= 1'b0;
      CORE_CLK_TICK   <= 1'b0;
      CORE_REF_SEL    <= REF_EXT_PIN;
      CORE_INPUT_CODE <= 5'h00;
      CORE_GAIN       <= GAIN_NONE;
    end else begin
      CONV_IRQ        <= flag_ff && ie_ff;
      CORE_EN         <= en_ff;
      CORE_CONVERTING <= (state_ff == ST_CONV);
      CORE_CLK_TICK   <= en_ff && tick;
      CORE_REF_SEL    <= act_ref_ff;
      CORE_INPUT_CODE <= act_code_ff;
      CORE_GAIN       <= acr_gain_of(act_code_ff);
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESETN);

  property p_flag_with_data;
    done && !frozen_ff |=> flag_ff && result_ff == $past(fmt_res);
  endproperty
  a_flag_with_data: assert property (p_flag_with_data)
    else $error("done flag rose without its result");

  property p_abort;
    wr_ctrl && !IO_WDATA[CS_EN] |=> state_ff == ST_IDLE ##1 !CORE_CONVERTING;
  endproperty
  a_abort: assert property (p_abort)
    else $error("disable did not abort the conversion");

  property p_start;
    state_ff == ST_IDLE && start_req |=> state_ff == ST_CONV
      ##1 (IO_RDATA[CS_START] || !$past(rd_ctrl));
  endproperty
  a_start: assert property (p_start)
    else $error("start did not begin a conversion");

  property p_len;
    state_ff == ST_IDLE && start_req && first_ff |=> len_ff == FIRST_CONV_CLKS;
  endproperty
  a_len: assert property (p_len)
    else $error("first conversion length wrong");

  property p_ref_hold;
    state_ff == ST_CONV && !done |=> $stable(act_ref_ff) && $stable(act_code_ff);
  endproperty
  a_ref_hold: assert property (p_ref_hold)
    else $error("selection changed during a conversion");

  property p_sign;
    done && !frozen_ff && acr_is_diff(act_code_ff) |=> result_ff[9] == $past(CORE_SAMPLE[15]);
  endproperty
  a_sign: assert property (p_sign)
    else $error("differential sign bit wrong");

  property p_se_floor;
    done && !frozen_ff && !acr_is_diff(act_code_ff) && CORE_SAMPLE < 16'sd0
      |=> result_ff == 10'h000;
  endproperty
  a_se_floor: assert property (p_se_floor)
    else $error("negative single-ended input not floored");

  property p_freeze;
    frozen_ff && !rd_hi |=> $stable(result_ff);
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("result changed while frozen");

  property p_flag_clear;
    flag_ff && IO_VECTOR_ACK && !set_flag |=> !flag_ff;
  endproperty
  a_flag_clear: assert property (p_flag_clear)
    else $error("vector did not clear the flag");

  property p_align;
    rd_lo && sel_ff[SEL_ALIGN] |=> IO_RDATA == {$past(result_ff[1:0]), 6'h00};
  endproperty
  a_align: assert property (p_align)
    else $error("left-aligned low byte wrong");

  property p_presc;
    en_ff && ps_ff == 3'd7 && $stable(ps_ff) && tick |=> !tick [*8];
  endproperty
  a_presc: assert property (p_presc)
    else $error("prescaler ticked too early");

  c_first_done: cover property (start_req && first_ff ##[1:700] done);
  c_free_run:   cover property (done && fr_ff ##[1:300] done);
  c_pending:    cover property (done && frozen_ff ##[1:50] rd_hi);
  c_abort:      cover property (state_ff == ST_CONV && wr_ctrl && !IO_WDATA[CS_EN]);

endmodule : acr_top

/* File: core/acr_pkg.sv */
package acr_pkg;

  // Register offsets in the I/O space; data space adds the bias.
  localparam logic [7:0] OFS_RES_LO      = 8'h04;
  localparam logic [7:0] OFS_RES_HI      = 8'h05;
  localparam logic [7:0] OFS_CTRL        = 8'h06;
  localparam logic [7:0] OFS_SEL         = 8'h07;
  localparam logic [7:0] DATA_SPACE_BIAS = 8'h20;
  localparam logic [7:0] RESET_VAL       = 8'h00;

  // Field positions in conv_control_status and conv_input_select.
  localparam int CS_EN    = 7;
  localparam int CS_START = 6;
  localparam int CS_FREE  = 5;
  localparam int CS_FLAG  = 4;
  localparam int CS_IE    = 3;
  localparam int SEL_ALIGN = 5;

  // Converter clock counts per conversion.
  localparam logic [4:0] FIRST_CONV_CLKS  = 5'd25;
  localparam logic [4:0] NORMAL_CONV_CLKS = 5'd13;

  // Result limits.
  localparam logic [9:0] SE_FULL_SCALE = 10'h3ff;
  localparam logic [9:0] DIFF_MAX      = 10'h1ff;
  localparam logic [9:0] DIFF_MIN      = 10'h200;
  localparam logic [4:0] CODE_DIFF_FIRST = 5'h08;
  localparam logic [4:0] CODE_DIFF_LAST  = 5'h1d;

  typedef enum logic [1:0] {REF_EXT_PIN, REF_ANALOG_SUPPLY, REF_RESERVED, REF_INT_2V56} acr_ref_e;
  typedef enum logic [1:0] {GAIN_NONE, GAIN_1X, GAIN_10X, GAIN_200X} acr_gain_e;

  function automatic logic acr_is_diff(input logic [4:0] code);
    acr_is_diff = (code >= CODE_DIFF_FIRST) && (code <= CODE_DIFF_LAST);
  endfunction : acr_is_diff

  // Codes 01xxx carry the amplified pairs; bit 1 picks 200x over 10x.
  function automatic acr_gain_e acr_gain_of(input logic [4:0] code);
    if (!acr_is_diff(code)) begin
      acr_gain_of = GAIN_NONE;
    end else if (code[4]) begin
      acr_gain_of = GAIN_1X;
    end else if (code[1]) begin
      acr_gain_of = GAIN_200X;
    end else begin
      acr_gain_of = GAIN_10X;
    end
  endfunction : acr_gain_of

  // Low bits of the prescaler counter that must all be set for one converter clock.
  function automatic logic [6:0] acr_div_mask(input logic [2:0] sel);
    if (sel <= 3'd1) begin
      acr_div_mask = 7'h01;
    end else begin
      acr_div_mask = 7'((8'h01 << sel) - 8'h01);
    end
  endfunction : acr_div_mask

  // Address decode for one register in either address space.
  function automatic logic acr_hit(input logic [7:0] addr, input logic ds, input logic [7:0] ofs);
    acr_hit = (addr == (ds ? 8'(ofs + DATA_SPACE_BIAS) : ofs));
  endfunction : acr_hit

endpackage : acr_pkg

/* File: core/acr_fmt.sv */
`timescale 1ns/1ns
module acr_fmt
  import acr_pkg::*;
(
  // Selection in effect
  input  wire logic [4:0]         code,
  // Raw difference from the core, in steps of the reference over 1024
  input  wire logic signed [15:0] sample,
  // Encoded 10-bit result
  output logic [9:0]              res
);

  logic signed [8:0]  gain_val;
  logic signed [24:0] prod;
  logic signed [24:0] half;

  always_comb begin
    case (acr_gain_of(code))
      GAIN_10X:  gain_val = 9'sd10;
      GAIN_200X: gain_val = 9'sd200;
      default:   gain_val = 9'sd1;
    endcase
  end

  // The core counts steps of Vref/1024; differential steps are Vref/512 per unit gain.
  assign prod = sample * gain_val;
  assign half = prod >>> 1;

  always_comb begin
    if (acr_is_diff(code)) begin
      if (half > 25'sd511) begin
        res = DIFF_MAX;
      end else if (half < -25'sd512) begin
        res = DIFF_MIN;
      end else begin
        res = half[9:0];
      end
    end else if (sample < 16'sd0) begin
      res = 10'h000;
    end else if (sample > 16'sd1023) begin
      res = SE_FULL_SCALE;
    end else begin
      res = sample[9:0];
    end
  end

endmodule : acr_fmt

/* File: sim/acr_core_model.sv */
`timescale 1ns/1ns
////////////////////////////////////////
module acr_core_model
  import acr_pkg::*;
#(
  parameter int EXT_MV = 3000,
  parameter int SUP_MV = 4096,
  parameter int INT_MV = 2560,
  parameter int BG_MV  = 1220
)
(
  // Selection in effect
  input  wire logic        converting,
  input  wire logic [1:0]  ref_sel,
  input  wire logic [4:0]  code,
  // Raw difference in steps of the reference over 1024
  output logic signed [15:0] sample
);
  int vin_mv [8];
  int pos_mv;
  int neg_mv;
  int ref_mv;
  int raw;

  always_comb begin
    ref_mv = (ref_sel == 2'h0) ? EXT_MV : (ref_sel == 2'h3) ? INT_MV : SUP_MV;
    neg_mv = 0;
    if (code <= 5'h07) begin
      pos_mv = vin_mv[code[2:0]];
    end else if (code >= 5'h1e) begin
      pos_mv = code[0] ? 0 : BG_MV;
    end else if (!code[4]) begin
      pos_mv = vin_mv[{1'b0, code[2], code[0]}];
      neg_mv = vin_mv[{1'b0, code[2], 1'b0}];
    end else begin
      pos_mv = vin_mv[code[2:0]];
      neg_mv = vin_mv[{1'b0, code[3], !code[3]}];
    end
    raw = (pos_mv - neg_mv) * 1024 / ref_mv;
    // Outside a conversion the core holds nothing valid, so a stale value must not pass.
    sample = converting ? 16'(raw) : ~16'(raw);
  end
endmodule : acr_core_model

/* File: sim/adc_result_and_control_regs_tb.sv */
`timescale 1ns/1ns
module adc_result_and_control_regs_tb
  import acr_pkg::*;
;
  logic              clk;
  logic              resetn;
  logic [7:0]        io_addr;
  logic              io_rd;
  logic              io_wr;
  logic [7:0]        io_wdata;
  logic [7:0]        io_rdata;
  logic              io_ack;
  logic              conv_irq;
  logic signed [15:0] core_sample;
  logic              core_en;
  logic              core_conv;
  logic              core_tick;
  logic [1:0]        core_ref;
  logic [4:0]        core_code;
  logic [1:0]        core_gain;
  int                err_count;
  int                tests_run;
  int                ticks;
  int                cycles;

  acr_top i_acr_top (
    .CLK(clk), .RESETN(resetn), .IO_ADDR(io_addr), .IO_DATA_SPACE(io_addr[5]),
    .IO_RD(io_rd), .IO_WR(io_wr), .IO_WDATA(io_wdata), .IO_RDATA(io_rdata),
    .IO_VECTOR_ACK(io_ack), .CONV_IRQ(conv_irq), .CORE_SAMPLE(core_sample),
    .CORE_EN(core_en), .CORE_CONVERTING(core_conv), .CORE_CLK_TICK(core_tick),
    .CORE_REF_SEL(core_ref), .CORE_INPUT_CODE(core_code), .CORE_GAIN(core_gain));

  acr_core_model i_acr_core_model (
    .converting(core_conv), .ref_sel(core_ref), .code(core_code), .sample(core_sample));

  always #50 clk = ~clk;

  // Converter clocks seen inside a conversion give its length.
  always @(posedge clk) begin
    if (core_tick === 1'b1 && core_conv === 1'b1) begin
      ticks++;
    end
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      complete_run();
    end
  end

  ////////////////////////////////////////
  task automatic complete_run();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input string nm, input logic [9:0] exp, input logic [9:0] got);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // Data-space addresses carry bit 5, so the space flag follows the address.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    io_addr = a;
    io_wdata = d;
    io_wr = 1'b1;
    @(negedge clk);
    io_wr = 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    io_addr = a;
    io_rd = 1'b1;
    @(negedge clk);
    io_rd = 1'b0;
    d = io_rdata;
  endtask : rd

  task automatic chk_res(input logic al, input logic [9:0] r);
    logic [7:0] lo;
    logic [7:0] hi;
    rd(OFS_RES_LO, lo);
    rd(OFS_RES_HI, hi);
    chk("result low", al ? {2'h0, r[1:0], 6'h00} : {2'h0, r[7:0]}, {2'h0, lo});
    chk("result high", al ? {2'h0, r[9:2]} : {8'h00, r[9:8]}, {2'h0, hi});
  endtask : chk_res

  task automatic wait_done();
    logic [7:0] s;
    int n;
    n = 0;
    s = 8'h00;
    while (s[CS_FLAG] !== 1'b1 && n < 400) begin
      rd(OFS_CTRL, s);
      n++;
    end
    chk("done flag", 10'h001, {9'h0, s[CS_FLAG]});
  endtask : wait_done

  task automatic conv(input logic [7:0] sel, input logic [9:0] r);
    wr(OFS_SEL, sel);
    wr(OFS_CTRL, 8'hc0);
    wait_done();
    chk_res(sel[SEL_ALIGN], r);
    wr(OFS_CTRL, 8'h90);
  endtask : conv

  ////////////////////////////////////////
  task automatic t_regs();
    logic [7:0] d;
    for (int k = 0; k < 8; k++) begin
      rd(8'(k < 4 ? 4 + k : 32 + k), d);
      chk("reset value", 10'h000, {2'h0, d});
    end
    wr(8'h27, 8'h5a);
    rd(OFS_SEL, d);
    chk("select", 10'h05a, {2'h0, d});
    rd(8'h28, d);
    chk("unmapped", 10'h000, {2'h0, d});
    wr(OFS_SEL, 8'h00);
    $display("test regs done");
  endtask : t_regs

  task automatic t_first();
    logic [7:0] s;
    ticks = 0;
    wr(OFS_SEL, 8'h45);
    wr(OFS_CTRL, 8'hc8);
    rd(OFS_CTRL, s);
    chk("start bit", 10'h001, {9'h0, s[CS_START]});
    wait_done();
    chk("first length", 10'd25, 10'(ticks));
    chk("irq", 10'h001, {9'h0, conv_irq});
    chk_res(1'b0, 10'h0fa);
    @(negedge clk);
    io_ack = 1'b1;
    @(negedge clk);
    io_ack = 1'b0;
    rd(OFS_CTRL, s);
    chk("flag after vector", 10'h000, {9'h0, s[CS_FLAG]});
    chk("irq low", 10'h000, {9'h0, conv_irq});
    ticks = 0;
    wr(OFS_CTRL, 8'hc0);
    wait_done();
    chk("later length", 10'd13, 10'(ticks));
    wr(OFS_CTRL, 8'h90);
    rd(OFS_CTRL, s);
    chk("flag after write", 10'h080, {2'h0, s});
    $display("test first done");
  endtask : t_first

  task automatic t_table();
    conv(8'h44, 10'h3ff);
    conv(8'h46, 10'h000);
    conv(8'h65, 10'h0fa);
    conv(8'h5e, 10'h131);
    conv(8'h5f, 10'h000);
    conv(8'h07, 10'h2aa);
    conv(8'hc7, 10'h320);
    conv(8'h4b, 10'h1ff);
    conv(8'h4f, 10'h200);
    conv(8'h4d, 10'h306);
    conv(8'h50, 10'h3c1);
    conv(8'h5d, 10'h03e);
    conv(8'h48, 10'h000);
    conv(8'h4e, 10'h000);
    $display("test table done");
  endtask : t_table

  task automatic t_align();
    conv(8'hed, 10'h270);
    chk("gain", 10'(GAIN_10X), 10'(core_gain));
    wr(OFS_SEL, 8'hcd);
    chk_res(1'b0, 10'h270);
    wr(OFS_CTRL, 8'hc0);
    wr(OFS_SEL, 8'hed);
    chk_res(1'b1, 10'h270);
    wait_done();
    wr(OFS_CTRL, 8'h90);
    $display("test align done");
  endtask : t_align

  task automatic t_defer();
    wr(OFS_SEL, 8'h41);
    wr(OFS_CTRL, 8'hc0);
    wr(OFS_SEL, 8'hc2);
    chk("code held", 10'h001, {5'h00, core_code});
    chk("ref held", 10'h001, {8'h00, core_ref});
    wait_done();
    chk_res(1'b0, 10'h096);
    chk("code applied", 10'h002, {5'h00, core_code});
    chk("ref applied", 10'h003, {8'h00, core_ref});
    wr(OFS_CTRL, 8'h90);
    $display("test defer done");
  endtask : t_defer

  task automatic t_abort();
    logic [7:0] s;
    wr(OFS_SEL, 8'h45);
    wr(OFS_CTRL, 8'hc0);
    wr(OFS_CTRL, 8'h00);
    repeat (60) @(negedge clk);
    rd(OFS_CTRL, s);
    chk("ctrl after abort", 10'h000, {2'h0, s});
    chk("core after abort", 10'h000, {8'h00, core_en, core_conv});
    $display("test abort done");
  endtask : t_abort

  task automatic t_freeze();
    logic [7:0] d;
    conv(8'h45, 10'h0fa);
    rd(OFS_RES_LO, d);
    wr(OFS_SEL, 8'h44);
    wr(OFS_CTRL, 8'hc0);
    repeat (60) @(negedge clk);
    rd(OFS_CTRL, d);
    chk("flag while frozen", 10'h000, {9'h0, d[CS_FLAG]});
    rd(OFS_RES_HI, d);
    chk("frozen high", 10'h000, {2'h0, d});
    wait_done();
    chk_res(1'b0, 10'h3ff);
    wr(OFS_CTRL, 8'h90);
    $display("test freeze done");
  endtask : t_freeze

  // Free running restarts by itself; clearing the mode lets the current conversion finish.
  task automatic t_free();
    logic [7:0] s;
    wr(OFS_SEL, 8'h45);
    wr(OFS_CTRL, 8'he0);
    wait_done();
    wr(OFS_CTRL, 8'hb0);
    wait_done();
    rd(OFS_CTRL, s);
    chk("free running", 10'h0f0, {2'h0, s});
    wr(OFS_CTRL, 8'h90);
    wait_done();
    chk_res(1'b0, 10'h0fa);
    rd(OFS_CTRL, s);
    chk("free run stopped", 10'h090, {2'h0, s});
    wr(OFS_CTRL, 8'h90);
    $display("test free done");
  endtask : t_free

  task automatic t_presc();
    int n;
    for (int p = 0; p < 8; p++) begin
      wr(OFS_CTRL, 8'h80 | 8'(p));
      repeat (2) @(negedge clk iff core_tick === 1'b1);
      n = 0;
      do begin
        @(negedge clk);
        n++;
      end while (core_tick !== 1'b1 && n < 300);
      chk("divider", 10'(p < 2 ? 2 : 1 << p), 10'(n));
    end
    wr(OFS_CTRL, 8'h00);
    $display("test prescaler done");
  endtask : t_presc

  initial begin
    clk = 1'b0;
    resetn = 1'b0;
    io_addr = 8'h00;
    io_rd = 1'b0;
    io_wr = 1'b0;
    io_wdata = 8'h00;
    io_ack = 1'b0;
    i_acr_core_model.vin_mv = '{100, 600, 500, 300, 4096, 1000, 0, 2000};
    repeat (3) @(negedge clk);
    resetn = 1'b1;
    t_regs();
    t_first();
    t_table();
    t_align();
    t_defer();
    t_abort();
    t_freeze();
    t_free();
    t_presc();
    complete_run();
  end
endmodule : adc_result_and_control_regs_tb
